// ---- common/sleep_pkg.sv ----
package sleep_pkg;
	// Power states, Gray coded along active -> light -> deep
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'h0,
		ST_LIGHT = 2'h1,
		ST_DEEP = 2'h3
	} power_state_e;

	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned SEC_TICK_CYCLES = CLK_HZ;
	localparam int unsigned TIME_W = 16;
	localparam int unsigned LINK_GAP_SEC = 90;
	localparam logic [TIME_W-1:0] SLEEP_TIMEOUT_RESET = 16'h0000;
	localparam int unsigned OMIT_W = 8;
	// Omit mask bit positions for record fields
	localparam int unsigned OMIT_PDOP = 0;
	localparam int unsigned OMIT_HDOP = 1;
	localparam int unsigned OMIT_ODO = 2;
	localparam int unsigned OMIT_SPEED = 3;
	localparam int unsigned OMIT_KEY_ID = 4;
	localparam int unsigned OMIT_CELL_ID = 5;
	localparam int unsigned OMIT_AREA = 6;
	localparam int unsigned OMIT_TEMP = 7;
	localparam logic [OMIT_W-1:0] OMIT_DEEP = 8'hFF;
	localparam logic [OMIT_W-1:0] OMIT_NONE = 8'h00;
endpackage

// ---- common/sync_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface sync_if;
	logic ignition;
	logic motion;
	logic usb;
	logic gps_fix;
	modport src(output ignition, output motion, output usb, output gps_fix);
	modport dst(input ignition, input motion, input usb, input gps_fix);
endinterface
`default_nettype wire

// ---- core/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync
	import sleep_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Raw pins
	input wire logic ignition_input,
	input wire logic motion_pin,
	input wire logic usb_pin,
	input wire logic gps_fix_pin,
	// Synchronised levels
	sync_if.src out
);
	logic [3:0] stage1;
	logic [3:0] stage2;
	logic [3:0] next_stage1;
	logic [3:0] next_stage2;

	always_comb begin
		next_stage1 = {gps_fix_pin, usb_pin, motion_pin, ignition_input};
		next_stage2 = stage1;
		if (!rst_n) begin
			next_stage1 = 4'h0;
			next_stage2 = 4'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign out.ignition = stage2[0];
	assign out.motion = stage2[1];
	assign out.usb = stage2[2];
	assign out.gps_fix = stage2[3];
endmodule
`default_nettype wire

// ---- core/sleep_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Sleep timeout counts only while the unit is stationary.
// - Light sleep entered only after timeout and all entry conditions together.
// - Light sleep powers GPS down and stops periodic records.
// - Light sleep still logs event records with last position and sends them.
// - Light entry needs enable, satellite time sync, no motion, ignition off.
// - Light sleep ends on motion or ignition on.
// - Deep sleep puts GPS to sleep and switches modem off.
// - Deep sleep keeps saving records; modem powered only to transmit.
// - Deep entry needs enable with timeout, sync, no motion, ignition off, no USB.
// - Deep entry needs record period above data link timeout.
// - Deep entry needs send period minus link timeout above ninety seconds.
// - Deep sleep ends on motion, ignition on or USB attached.
// - Deep sleep records omit DOP, odometer, speed, key, cell, area, temperature, GPS power; OMIT_DEEP has no GPS power bit.
// - Without reception records keep coming using last known position.
module sleep_ctrl
	import sleep_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SEC_TICK_CYCLES
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Pins from outside
	input wire logic ignition_input,
	input wire logic motion_pin,
	input wire logic usb_pin,
	input wire logic gps_fix_pin,
	// Configuration, seconds
	input wire logic light_enable,
	input wire logic deep_enable,
	input wire logic [TIME_W-1:0] sleep_timeout,
	input wire logic [TIME_W-1:0] min_record_period,
	input wire logic [TIME_W-1:0] link_timeout,
	input wire logic [TIME_W-1:0] send_period,
	// Firmware requests
	input wire logic periodic_req,
	input wire logic event_req,
	input wire logic tx_pending,
	input wire logic tx_done,
	// Power outputs
	output logic gps_power,
	output logic gps_sleep,
	output logic modem_power,
	// Record outputs
	output logic record_strobe,
	output logic record_is_event,
	output logic record_use_last_pos,
	output logic [OMIT_W-1:0] record_omit,
	output logic record_forward,
	// Status
	output logic [1:0] power_state,
	output logic timeout_reached
);
	// Elaboration-time refusal of a tick divider that cannot count
	if (TICK_CYCLES < 2) begin : g_tick_check
		$error("TICK_CYCLES too small");
	end

	localparam int unsigned TICK_W = $clog2(TICK_CYCLES);

	sync_if pins();

	pin_sync u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ignition_input(ignition_input),
		.motion_pin(motion_pin),
		.usb_pin(usb_pin),
		.gps_fix_pin(gps_fix_pin),
		.out(pins)
	);

	function automatic logic wake_light(input logic mot, input logic ign);
		wake_light = mot | ign;
	endfunction

	power_state_e state;
	power_state_e next_state;
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic [TIME_W-1:0] idle_sec;
	logic [TIME_W-1:0] next_idle_sec;
	logic reached;
	logic next_reached;
	logic time_synced;
	logic next_time_synced;
	logic tx_active;
	logic next_tx_active;
	logic sec_tick;
	logic stationary;
	logic light_ok;
	logic deep_ok;
	logic [TIME_W:0] send_gap;
	logic next_gps_power;
	logic next_gps_sleep;
	logic next_modem_power;
	logic next_strobe;
	logic next_is_event;
	logic next_use_last;
	logic [OMIT_W-1:0] next_omit;
	logic next_forward;

	assign stationary = !pins.motion && !pins.ignition;
	assign sec_tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
	assign send_gap = {1'b0, send_period} - {1'b0, link_timeout};

	always_comb begin
		light_ok = light_enable && reached && time_synced && !pins.motion && !pins.ignition;
		deep_ok = deep_enable && (sleep_timeout != SLEEP_TIMEOUT_RESET) && reached && time_synced
			&& !pins.motion && !pins.ignition && !pins.usb
			&& (min_record_period > link_timeout)
			&& !send_gap[TIME_W] && (send_gap[TIME_W-1:0] > TIME_W'(LINK_GAP_SEC));
	end

	// Timing and state
	always_comb begin
		next_tick_cnt = sec_tick ? '0 : tick_cnt + 1'b1;
		next_idle_sec = idle_sec;
		next_reached = reached;
		next_time_synced = time_synced | pins.gps_fix;
		next_state = state;
		if (!stationary) begin
			next_idle_sec = '0;
			next_reached = 1'b0;
		end else if (sec_tick && !reached) begin
			if (idle_sec + 1'b1 >= sleep_timeout) begin
				next_reached = 1'b1;
			end
			next_idle_sec = idle_sec + 1'b1;
		end
		case (state)
			ST_ACTIVE: begin
				if (deep_ok) begin
					next_state = ST_DEEP;
				end else if (light_ok) begin
					next_state = ST_LIGHT;
				end
			end
			ST_LIGHT: begin
				if (wake_light(pins.motion, pins.ignition)) begin
					next_state = ST_ACTIVE;
				end else if (deep_ok) begin
					next_state = ST_DEEP;
				end
			end
			ST_DEEP: begin
				if (wake_light(pins.motion, pins.ignition) || pins.usb) begin
					next_state = ST_ACTIVE;
				end
			end
			default: next_state = ST_ACTIVE;
		endcase
		// Any exit restarts the timeout, else a USB exit falls straight back asleep
		if (state != ST_ACTIVE && next_state == ST_ACTIVE) begin
			next_idle_sec = '0;
			next_reached = 1'b0;
		end
		if (!rst_n) begin
			next_tick_cnt = '0;
			next_idle_sec = '0;
			next_reached = 1'b0;
			next_time_synced = 1'b0;
			next_state = ST_ACTIVE;
		end
	end

	always_ff @(posedge core_clk) begin
		tick_cnt <= next_tick_cnt;
		idle_sec <= next_idle_sec;
		reached <= next_reached;
		time_synced <= next_time_synced;
		state <= next_state;
	end

	// Power switches and records
	always_comb begin
		next_tx_active = tx_active;
		if (next_state == ST_DEEP) begin
			if (tx_pending && !tx_active) begin
				next_tx_active = 1'b1;
			end else if (tx_done) begin
				next_tx_active = 1'b0;
			end
		end else begin
			next_tx_active = 1'b0;
		end
		next_gps_power = (next_state == ST_ACTIVE);
		next_gps_sleep = (next_state == ST_DEEP);
		next_modem_power = (next_state != ST_DEEP) || next_tx_active;
		next_strobe = 1'b0;
		next_is_event = 1'b0;
		next_use_last = 1'b0;
		next_omit = OMIT_NONE;
		next_forward = 1'b0;
		if (event_req) begin
			next_strobe = 1'b1;
			next_is_event = 1'b1;
			next_forward = 1'b1;
		end else if (periodic_req && state != ST_LIGHT) begin
			next_strobe = 1'b1;
			next_forward = 1'b1;
		end
		if (next_strobe) begin
			next_use_last = (state != ST_ACTIVE) || !pins.gps_fix;
			// Mask follows the state shown with the strobe
			if (next_state == ST_DEEP) begin
				next_omit = OMIT_DEEP;
			end
		end
		if (!rst_n) begin
			next_tx_active = 1'b0;
			next_gps_power = 1'b1;
			next_gps_sleep = 1'b0;
			next_modem_power = 1'b1;
			next_strobe = 1'b0;
			next_is_event = 1'b0;
			next_use_last = 1'b0;
			next_omit = OMIT_NONE;
			next_forward = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		tx_active <= next_tx_active;
		gps_power <= next_gps_power;
		gps_sleep <= next_gps_sleep;
		modem_power <= next_modem_power;
		record_strobe <= next_strobe;
		record_is_event <= next_is_event;
		record_use_last_pos <= next_use_last;
		record_omit <= next_omit;
		record_forward <= next_forward;
		power_state <= next_state;
		timeout_reached <= next_reached;
	end
endmodule
`default_nettype wire

// ---- bench/gps_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module gps_model (
	// Clock
	input wire logic core_clk,
	// Power control
	input wire logic gps_power,
	input wire logic gps_sleep,
	// Sky view and fix line
	input wire logic sky,
	output logic gps_fix_pin
);
	logic [1:0] warm = 2'h0;
	// Fix only after warm-up with power and sky
	always_ff @(posedge core_clk) begin
		warm <= (gps_power && !gps_sleep && sky) ? warm + 2'(warm != 2'h3) : 2'h0;
	end
	assign gps_fix_pin = (warm == 2'h3);
endmodule
`default_nettype wire

// ---- bench/sleep_ctrl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module sleep_ctrl_chk
	import sleep_pkg::*;
(
	// Clock, reset, pins
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ignition_input,
	input wire logic motion_pin,
	input wire logic usb_pin,
	// Requests
	input wire logic periodic_req,
	input wire logic event_req,
	// Outputs
	input wire logic gps_sleep,
	input wire logic record_strobe,
	input wire logic record_is_event,
	input wire logic record_forward,
	input wire logic [OMIT_W-1:0] record_omit,
	input wire logic [1:0] power_state,
	input wire logic timeout_reached
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence usb_held; usb_pin [*3]; endsequence
	sequence wake_held; (motion_pin || ignition_input) [*3]; endsequence
	one_state_a: assert property (power_state != 2'h2) else $error("illegal power state");
	light_periodic_a: assert property (power_state == ST_LIGHT && periodic_req && !event_req |=> !record_strobe)
		else $error("periodic record in light sleep");
	event_rec_a: assert property (event_req |=> record_strobe && record_is_event && record_forward)
		else $error("event record missing");
	sleep_entry_a: assert property (power_state != ST_ACTIVE && $past(power_state) == ST_ACTIVE |-> $past(timeout_reached))
		else $error("sleep entered before timeout");
	deep_gps_a: assert property (power_state == ST_DEEP |-> gps_sleep) else $error("gps awake in deep sleep");
	deep_omit_a: assert property (record_strobe && power_state == ST_DEEP |-> record_omit == OMIT_DEEP)
		else $error("deep record fields kept");
	usb_exit_a: assert property (usb_held |=> power_state != ST_DEEP) else $error("deep kept with usb");
	wake_exit_a: assert property (wake_held |=> power_state == ST_ACTIVE) else $error("no wake");
endmodule
bind sleep_ctrl sleep_ctrl_chk i_sleep_ctrl_chk (.*);
`default_nettype wire

// ---- bench/sleep_ctrl_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sleep_ctrl_tb
	import sleep_pkg::*;
;
	logic core_clk = 1'b0, rst_n = 1'b0, ignition_input = 1'b0, motion_pin = 1'b0, usb_pin = 1'b0, sky = 1'b0;
	logic light_enable = 1'b1, deep_enable = 1'b0, periodic_req = 1'b0, event_req = 1'b0, tx_pending = 1'b0;
	logic tx_done = 1'b0, gps_fix_pin, gps_power, gps_sleep, modem_power, record_strobe, record_is_event;
	logic record_use_last_pos, record_forward, timeout_reached;
	logic [TIME_W-1:0] sleep_timeout = 16'h0002, min_record_period, link_timeout = 16'h0064, send_period;
	logic [OMIT_W-1:0] record_omit;
	logic [1:0] power_state;
	int fails = 0, checks_done = 0;
	always #12.5 core_clk = ~core_clk;
	sleep_ctrl #(.TICK_CYCLES(4)) i_sleep_ctrl (
		.core_clk(core_clk), .rst_n(rst_n), .ignition_input(ignition_input), .motion_pin(motion_pin),
		.usb_pin(usb_pin), .gps_fix_pin(gps_fix_pin), .light_enable(light_enable), .deep_enable(deep_enable),
		.sleep_timeout(sleep_timeout), .min_record_period(min_record_period), .link_timeout(link_timeout),
		.send_period(send_period), .periodic_req(periodic_req), .event_req(event_req), .tx_pending(tx_pending),
		.tx_done(tx_done), .gps_power(gps_power), .gps_sleep(gps_sleep), .modem_power(modem_power),
		.record_strobe(record_strobe), .record_is_event(record_is_event),
		.record_use_last_pos(record_use_last_pos), .record_omit(record_omit), .record_forward(record_forward),
		.power_state(power_state), .timeout_reached(timeout_reached)
	);
	gps_model i_gps_model (
		.core_clk(core_clk), .gps_power(gps_power), .gps_sleep(gps_sleep), .sky(sky), .gps_fix_pin(gps_fix_pin)
	);
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic settle(input logic [1:0] s);
		int n;
		n = 0;
		while (power_state !== s && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		chk(power_state, s, "power state");
	endtask
	task automatic req(input logic ev);
		@(negedge core_clk);
		event_req = ev;
		periodic_req = !ev;
		@(negedge core_clk);
		event_req = 1'b0;
		periodic_req = 1'b0;
	endtask
	task automatic wake(input logic ign);
		if (ign) ignition_input = 1'b1;
		else motion_pin = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(power_state, ST_ACTIVE, "wake");
		motion_pin = 1'b0;
		ignition_input = 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		min_record_period = 16'h0096;
		send_period = 16'h00C8;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		chk({gps_power, modem_power, power_state}, 4'hC, "reset outputs");
		sky = 1'b1;
		settle(ST_LIGHT);
		chk({gps_power, timeout_reached}, 2'h1, "gps in light");
		req(1'b0);
		chk(record_strobe, 1'b0, "periodic in light");
		req(1'b1);
		chk({record_strobe, record_is_event, record_use_last_pos, record_forward}, 4'hF, "event in light");
		for (int w = 0; w < 2; w++) begin
			settle(ST_LIGHT);
			wake(w[0]);
		end
		$display("test light done");
		deep_enable = 1'b1;
		for (int c = 0; c < 3; c++) begin
			min_record_period = (c == 0) ? 16'h0064 : 16'h0096;
			send_period = (c == 1) ? 16'h00BE : 16'h00C8;
			usb_pin = (c == 2);
			settle(ST_LIGHT);
			repeat (20) @(negedge core_clk);
			chk(power_state, ST_LIGHT, "deep refused");
			wake(1'b0);
		end
		usb_pin = 1'b0;
		$display("test deep refusal done");
		settle(ST_DEEP);
		chk({gps_sleep, modem_power}, 2'h2, "deep power");
		tx_pending = 1'b1;
		@(negedge core_clk);
		chk(modem_power, 1'b1, "modem up to send");
		tx_pending = 1'b0;
		tx_done = 1'b1;
		@(negedge core_clk);
		tx_done = 1'b0;
		chk(modem_power, 1'b0, "modem off after send");
		req(1'b0);
		chk({record_strobe, record_omit}, 9'h1FF, "deep record");
		sky = 1'b0;
		usb_pin = 1'b1;
		repeat (4) @(negedge core_clk);
		chk(power_state, ST_ACTIVE, "usb exit");
		chk(timeout_reached, 1'b0, "timeout restarts after exit");
		req(1'b0);
		chk({record_strobe, record_use_last_pos}, 2'h3, "record without fix");
		$display("test deep done");
		results();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		results();
	end
endmodule
`default_nettype wire
